//--- src/fpos_pkg.sv
// constants for the flow pulse output select block
// Operation
// - five selectable pulse output sources
// - pick-up one source carries leading train
// - pick-up two source carries trailing train
// - combined source doubles pulse rate
// - direction source high forward, low reverse
// - limit source is static limit level
// - driver mode push-pull, sinking or sourcing
// - button selects three test states, LED shows
// - state one normal, LED pulses every 3 s
// - state two 10 Hz quadrature, out1 leads
// - state three 50 Hz, out2 leads
// - analog output is a 16-bit code
// - analog code refreshed at most every 100 ms
// - normal analog clamp at full scale +2.5%
// - error drives analog to full scale +10%
// - four voltage spans, 0-10 V default
package fpos_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // apb map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ANA  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ  = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_CODE = 8'h14;
  // ctrl fields
  localparam int CTL_SRC_LSB  = 0;
  localparam int CTL_DRV_LSB  = 4;
  localparam int CTL_SPAN_LSB = 8;
  localparam int CTL_ERR_BIT  = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  // irq bits: 0 test state change, 1 analog update, 2 clamp hit
  localparam int IRQ_W = 3;
  // timing
  localparam int unsigned LED_MS     = 3000;
  localparam int unsigned ANA_MS     = 100;
  localparam int unsigned T10_HZ     = 10;
  localparam int unsigned T50_HZ     = 50;
  localparam int unsigned DEB_MS     = 20;
  localparam int unsigned LED_ON_MS  = 100;
  localparam int unsigned ANA_CYC    = CLK_HZ / 1000 * ANA_MS;
  localparam int unsigned LED_CYC    = CLK_HZ / 1000 * LED_MS;
  localparam int unsigned LEDON_CYC  = CLK_HZ / 1000 * LED_ON_MS;
  localparam int unsigned DEB_CYC    = CLK_HZ / 1000 * DEB_MS;
  // quarter period counts of the test trains
  localparam int unsigned Q10_CYC    = CLK_HZ / (4 * T10_HZ);
  localparam int unsigned Q50_CYC    = CLK_HZ / (4 * T50_HZ);
  // clamp levels in 1/1000 of full scale
  localparam int unsigned CLAMP_PM   = 1025;
  localparam int unsigned ERR_PM     = 1100;
  localparam logic [15:0] CODE_MAX   = 16'hFFFF;
  typedef enum logic [2:0]
  {
    SRC_P1   = 3'h0,
    SRC_P2   = 3'h1,
    SRC_BOTH = 3'h2,
    SRC_DIR  = 3'h3,
    SRC_LIM  = 3'h4
  } fpos_src_t;
  typedef enum logic [1:0]
  {
    DRV_PP  = 2'h0,
    DRV_SNK = 2'h1,
    DRV_SRC = 2'h2
  } fpos_drv_t;
  typedef enum logic [1:0]
  {
    SPAN_0_5  = 2'h0,
    SPAN_1_5  = 2'h1,
    SPAN_0_10 = 2'h2,
    SPAN_2_10 = 2'h3
  } fpos_span_t;
  // gray coded test states
  typedef enum logic [1:0]
  {
    TST_NORM = 2'b00,
    TST_F10  = 2'b01,
    TST_F50  = 2'b11
  } fpos_tst_t;
endpackage

//--- src/fpos_top.sv
// flow pulse output select, test mode and analog code path
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpos_top
#(
  parameter int unsigned ANA_CYC   = fpos_pkg::ANA_CYC,
  parameter int unsigned LED_CYC   = fpos_pkg::LED_CYC,
  parameter int unsigned LEDON_CYC = fpos_pkg::LEDON_CYC,
  parameter int unsigned DEB_CYC   = fpos_pkg::DEB_CYC,
  parameter int unsigned Q10_CYC   = fpos_pkg::Q10_CYC,
  parameter int unsigned Q50_CYC   = fpos_pkg::Q50_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pickup1,
  input  wire logic        pickup2,
  input  wire logic        flow_fwd,
  input  wire logic        limit_hit,
  input  wire logic        test_btn,
  output logic             pulse_out1_o,
  output logic             pulse_out1_oe,
  output logic             pulse_out2_o,
  output logic             pulse_out2_oe,
  output logic             led_green,
  output logic [1:0]       test_state,
  output logic [15:0]      ana_code,
  output logic [1:0]       ana_span,
  output logic             irq
);
  import fpos_pkg::*;

  logic [31:0] ctrl_r;
  logic [15:0] ana_req_r;
  logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r;
  fpos_tst_t tst_r, tst_nxt;

  // apb decode, zero wait state
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire hit_c  = paddr == OFS_CTRL;
  wire hit_a  = paddr == OFS_ANA;
  wire hit_s  = paddr == OFS_STAT;
  wire hit_i  = paddr == OFS_IRQ;
  wire hit_m  = paddr == OFS_MASK;
  wire hit_k  = paddr == OFS_CODE;
  wire mapped = hit_c | hit_a | hit_s | hit_i | hit_m | hit_k;

  wire [2:0]  src_sel  = ctrl_r[CTL_SRC_LSB +: 3];
  wire [1:0]  drv_sel  = ctrl_r[CTL_DRV_LSB +: 2];
  wire [1:0]  span_sel = ctrl_r[CTL_SPAN_LSB +: 2];
  wire        err_flag = ctrl_r[CTL_ERR_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r    <= CTRL_RST;
      ana_req_r <= 16'h0000;
      mask_r    <= '0;
    end
    else if (wr)
    begin
      if (hit_c) ctrl_r    <= pwdata;
      if (hit_a) ana_req_r <= pwdata[15:0];
      if (hit_m) mask_r    <= pwdata[IRQ_W-1:0];
    end
  end

  // button debounce: stable level held for DEB_CYC
  logic        btn_r, btn_prev_r;
  logic [31:0] deb_cnt_r;
  wire btn_press = btn_r & ~btn_prev_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      btn_r      <= 1'b0;
      btn_prev_r <= 1'b0;
      deb_cnt_r  <= '0;
    end
    else
    begin
      btn_prev_r <= btn_r;
      if (test_btn == btn_r)
        deb_cnt_r <= '0;
      else if (deb_cnt_r >= DEB_CYC - 1)
      begin
        btn_r     <= test_btn;
        deb_cnt_r <= '0;
      end
      else
        deb_cnt_r <= deb_cnt_r + 32'd1;
    end
  end

  always_comb
  begin
    tst_nxt = tst_r;
    if (btn_press)
    begin
      unique case (tst_r)
        TST_NORM: tst_nxt = TST_F10;
        TST_F10:  tst_nxt = TST_F50;
        TST_F50:  tst_nxt = TST_NORM;
        default:  tst_nxt = TST_NORM;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) tst_r <= TST_NORM;
    else          tst_r <= tst_nxt;
  end

  // quadrature test generator: phase counter steps each quarter period
  logic [31:0] q_cnt_r;
  logic [1:0]  q_ph_r;
  wire [31:0] q_len = (tst_r == TST_F50) ? Q50_CYC : Q10_CYC;
  wire        q_step = q_cnt_r >= q_len - 1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_cnt_r <= '0;
      q_ph_r  <= 2'b00;
    end
    else if (tst_r == TST_NORM || tst_r != tst_nxt)
    begin
      q_cnt_r <= '0;
      q_ph_r  <= 2'b00;
    end
    else if (q_step)
    begin
      q_cnt_r <= '0;
      q_ph_r  <= q_ph_r + 2'd1;
    end
    else
      q_cnt_r <= q_cnt_r + 32'd1;
  end
  // q_a is high in phases 0 and 1, q_b in 1 and 2: q_a leads a quarter
  wire q_a    = (q_ph_r == 2'd0) | (q_ph_r == 2'd1);
  wire q_b    = (q_ph_r == 2'd1) | (q_ph_r == 2'd2);

  logic sel_out1, sel_out2;
  always_comb
  begin
    unique case (src_sel)
      SRC_P1:
      begin
        sel_out1 = pickup1;
        sel_out2 = pickup2;
      end
      SRC_P2:
      begin
        sel_out1 = pickup2;
        sel_out2 = pickup1;
      end
      SRC_BOTH:
      begin
        sel_out1 = pickup1 ^ pickup2;
        sel_out2 = pickup1 ^ pickup2;
      end
      SRC_DIR:
      begin
        sel_out1 = flow_fwd;
        sel_out2 = flow_fwd;
      end
      SRC_LIM:
      begin
        sel_out1 = limit_hit;
        sel_out2 = limit_hit;
      end
      default:
      begin
        sel_out1 = 1'b0;
        sel_out2 = 1'b0;
      end
    endcase
  end

  // out1 leads in 10 Hz; out2 leads in 50 Hz
  wire lvl1 = (tst_r == TST_NORM) ? sel_out1 :
              (tst_r == TST_F10)  ? q_a : q_b;
  wire lvl2 = (tst_r == TST_NORM) ? sel_out2 :
              (tst_r == TST_F10)  ? q_b : q_a;

  // driver style: sinking only pulls low, sourcing only drives high
  function automatic logic drv_en(input logic [1:0] m, input logic v);
    drv_en = (m == DRV_SNK) ? ~v : (m == DRV_SRC) ? v : 1'b1;
  endfunction

  // led: short blink every LED_CYC in normal, steady while testing
  logic [31:0] led_cnt_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_cnt_r <= '0;
    else if (led_cnt_r >= LED_CYC - 1)
      led_cnt_r <= '0;
    else
      led_cnt_r <= led_cnt_r + 32'd1;
  end
  wire led_nxt = (tst_r == TST_NORM) ? (led_cnt_r < LEDON_CYC) : 1'b1;

  // clamp or error level, then update every ANA_CYC
  // error level is the top code, so both levels share one full scale
  logic [15:0] clamp_lvl;
  assign clamp_lvl = 16'((32'(CODE_MAX) * CLAMP_PM) / ERR_PM);
  wire [15:0] err_lvl  = CODE_MAX;
  wire        over     = ana_req_r > clamp_lvl;
  wire [15:0] code_nxt = err_flag ? err_lvl : (over ? clamp_lvl : ana_req_r);
  logic [31:0] ana_cnt_r;
  wire ana_tick = ana_cnt_r >= ANA_CYC - 1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) ana_cnt_r <= '0;
    else if (ana_tick) ana_cnt_r <= '0;
    else ana_cnt_r <= ana_cnt_r + 32'd1;
  end

  // interrupt status: set wins over read clear
  wire [IRQ_W-1:0] ev = {ana_tick & over & ~err_flag, ana_tick,
                         tst_r != tst_nxt};
  assign stat_nxt = ((rd & hit_i) ? '0 : stat_r) | ev;

  // status read shows events of the setup cycle, which the clear drops
  wire [31:0] rd_word = hit_c ? ctrl_r :
                        hit_a ? {16'h0000, ana_req_r} :
                        hit_s ? {27'h000_0000, tst_r, src_sel} :
                        hit_i ? {29'h0000_0000, stat_nxt} :
                        hit_m ? {29'h0000_0000, mask_r} :
                        hit_k ? {16'h0000, ana_code} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_r        <= '0;
      ana_code      <= 16'h0000;
      ana_span      <= SPAN_0_10;
      pulse_out1_o  <= 1'b0;
      pulse_out1_oe <= 1'b0;
      pulse_out2_o  <= 1'b0;
      pulse_out2_oe <= 1'b0;
      led_green     <= 1'b0;
      test_state    <= TST_NORM;
      irq           <= 1'b0;
      prdata        <= '0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end
    else
    begin
      stat_r        <= stat_nxt;
      // 16-bit code refreshed on the interval tick
      if (ana_tick) ana_code <= code_nxt;
      // span follows ctrl, 0-10 V after reset
      ana_span      <= span_sel;
      pulse_out1_o  <= lvl1;
      pulse_out1_oe <= drv_en(drv_sel, lvl1);
      pulse_out2_o  <= lvl2;
      pulse_out2_oe <= drv_en(drv_sel, lvl2);
      led_green     <= led_nxt;
      test_state    <= tst_r;
      irq           <= |(stat_nxt & mask_r);
      pready        <= psel & ~penable;
      pslverr       <= psel & ~penable & ~mapped;
      prdata        <= rd_word;
    end
  end

  // assertions
  a_irq_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    1'b1 |=> irq == |($past(stat_nxt) & $past(mask_r)))
    else $error("irq level wrong");
  a_state_cycle: assert property (@(posedge pclk)
    disable iff (!presetn)
    btn_press && tst_r == TST_F50 |=> tst_r == TST_NORM)
    else $error("test state did not wrap");
  a_state_adv: assert property (@(posedge pclk)
    disable iff (!presetn)
    btn_press && tst_r == TST_NORM |=> tst_r == TST_F10)
    else $error("test state did not advance");
  a_led_test: assert property (@(posedge pclk)
    disable iff (!presetn)
    test_state != TST_NORM |-> led_green)
    else $error("led not steady in test state");
  a_p1_src: assert property (@(posedge pclk)
    disable iff (!presetn || tst_r != TST_NORM)
    src_sel == SRC_P1 |=> pulse_out1_o == $past(pickup1))
    else $error("pick-up one output wrong");
  a_p2_src: assert property (@(posedge pclk)
    disable iff (!presetn || tst_r != TST_NORM)
    src_sel == SRC_P2 |=> pulse_out1_o == $past(pickup2))
    else $error("pick-up two output wrong");
  a_both_src: assert property (@(posedge pclk)
    disable iff (!presetn || tst_r != TST_NORM)
    src_sel == SRC_BOTH |=> pulse_out1_o == ($past(pickup1) ^ $past(pickup2)))
    else $error("combined output wrong");
  a_dir_src: assert property (@(posedge pclk)
    disable iff (!presetn)
    tst_r == TST_NORM && src_sel == SRC_DIR |=>
    pulse_out1_o == $past(flow_fwd))
    else $error("direction output wrong");
  a_lim_src: assert property (@(posedge pclk)
    disable iff (!presetn)
    tst_r == TST_NORM && src_sel == SRC_LIM |=>
    pulse_out2_o == $past(limit_hit))
    else $error("limit output wrong");
  a_lead_10: assert property (@(posedge pclk)
    disable iff (!presetn)
    test_state == TST_F10 && $rose(pulse_out1_o) |-> !pulse_out2_o)
    else $error("10 Hz phase order wrong");
  a_lead_50: assert property (@(posedge pclk)
    disable iff (!presetn)
    test_state == TST_F50 && $rose(pulse_out1_o) |-> pulse_out2_o)
    else $error("50 Hz phase order wrong");
  a_span_follow: assert property (@(posedge pclk)
    disable iff (!presetn)
    1'b1 |=> ana_span == $past(span_sel))
    else $error("span output wrong");
  a_code_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    !ana_tick |=> $stable(ana_code))
    else $error("analog code changed early");
  a_err_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    ana_tick && err_flag |=> ana_code == err_lvl)
    else $error("error level not driven");
  a_clamp_lvl: assert property (@(posedge pclk)
    disable iff (!presetn)
    ana_tick && !err_flag |=> ana_code <= clamp_lvl)
    else $error("clamp exceeded");
  a_sink_mode: assert property (@(posedge pclk)
    disable iff (!presetn)
    drv_sel == DRV_SNK |=> !(pulse_out1_oe && pulse_out1_o))
    else $error("sinking driver drove high");
  c_test10: cover property (@(posedge pclk) tst_r == TST_F10 && q_step);
  c_test50: cover property (@(posedge pclk) tst_r == TST_F50 && q_step);
  c_irq:    cover property (@(posedge pclk) irq);
  c_clamp:  cover property (@(posedge pclk) ana_tick && over && !err_flag);
  c_error:  cover property (@(posedge pclk) ana_tick && err_flag);
endmodule
`default_nettype wire

//--- tb/fpos_pulse_rx.sv
// receiver model on one pulse output line
`timescale 1ns/1ps
`default_nettype none
module fpos_pulse_rx
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic drv_o,
  input  wire logic drv_oe,
  input  wire logic pull_up,
  output logic      line,
  output int        edges
);
  logic line_q;
  // a released line settles to the resistor level
  assign line = drv_oe ? drv_o : pull_up;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_q <= 1'b1;
      edges  <= 0;
    end
    else
    begin
      line_q <= line;
      edges  <= edges + int'(line & ~line_q);
    end
  end
endmodule
`default_nettype wire

//--- tb/fpos_top_tb_top.sv
// self-checking bench of the flow pulse output select block
`timescale 1ns/1ps
`default_nettype none
module fpos_top_tb_top;
  import fpos_pkg::*;
  localparam int ANA = 50;
  localparam int DEB = 4;
  localparam int Q10 = 8;
  localparam int Q50 = 4;
  localparam int LEDP = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        pickup1, pickup2, flow_fwd, limit_hit, test_btn, irq;
  logic        pulse_out1_o, pulse_out1_oe, pulse_out2_o, pulse_out2_oe;
  logic        led_green, pull_up, line1;
  logic [1:0]  test_state, ana_span;
  logic [15:0] ana_code;
  logic [15:0] ana_q = '0;
  int          errors, num_checks, edges, lvl, n;
  int          since = ANA;
  logic [1:0]  ts_tab [3] = '{2'b00, 2'b01, 2'b11};
  logic [1:0]  gr [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  fpos_top #(.ANA_CYC(ANA), .LED_CYC(LEDP), .LEDON_CYC(10), .DEB_CYC(DEB),
    .Q10_CYC(Q10), .Q50_CYC(Q50)) fpos_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pickup1(pickup1), .pickup2(pickup2), .flow_fwd(flow_fwd),
    .limit_hit(limit_hit), .test_btn(test_btn), .pulse_out1_o(pulse_out1_o),
    .pulse_out1_oe(pulse_out1_oe), .pulse_out2_o(pulse_out2_o),
    .pulse_out2_oe(pulse_out2_oe), .led_green(led_green),
    .test_state(test_state), .ana_code(ana_code), .ana_span(ana_span),
    .irq(irq));
  fpos_pulse_rx fpos_pulse_rx_i (.clk(pclk), .rst_n(presetn),
    .drv_o(pulse_out1_o), .drv_oe(pulse_out1_oe), .pull_up(pull_up),
    .line(line1), .edges(edges));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait for out1 (w 0) or the led (w 1) to reach level l, adding cycles
  task automatic wt(input int w, input logic l, inout int c);
    int k;
    k = 0;
    while (((w == 0) ? pulse_out1_o : led_green) !== l && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 2000) chk(0, 1);
    c += k;
  endtask
  task automatic press();
    test_btn <= 1'b1;
    repeat (DEB + 4) @(posedge pclk);
    test_btn <= 1'b0;
    repeat (DEB + 4) @(posedge pclk);
  endtask
  task automatic qchk(input int q, input logic lead2);
    wt(0, 0, n);
    wt(0, 1, n);
    chk(pulse_out2_o, lead2);
    n = 0;
    wt(0, 0, n);
    chk(n, 2 * q);
  endtask
  function automatic logic exp_src(input int s);
    case (s)
      0: return pickup1;
      1: return pickup2;
      2: return pickup1 ^ pickup2;
      3: return flow_fwd;
      default: return limit_hit;
    endcase
  endfunction
  function automatic logic [31:0] exp_ana(input logic [31:0] r, input bit e);
    logic [31:0] c;
    c = 32'(CODE_MAX) * CLAMP_PM / ERR_PM;
    return e ? 32'(CODE_MAX) : ((r > c) ? c : r);
  endfunction
  always @(posedge pclk)
  begin
    if (ana_code !== ana_q)
    begin
      chk(since >= ANA - 1, 1);
      since = 0;
    end
    else
      since++;
    ana_q = ana_code;
  end
  initial
  begin
    #(25 * 30000);
    errors++;
    stop_test();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pickup1, pickup2, flow_fwd, limit_hit, test_btn} = '0;
    pull_up = 1'b1;
    presetn = 1'b0;
    void'($urandom(32'h3493_ff70));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_CTRL, 0, rd);
    chk(rd, CTRL_RST);
    chk(ana_span, 2);
    chk(pulse_out1_oe, 1);
    apb(0, 8'h18, 0, rd);
    chk(rd, 0);
    chk(serr, 1);
    for (int s = 0; s < 5; s++)
    begin
      apb(1, OFS_CTRL, s, rd);
      apb(0, OFS_STAT, 0, rd);
      chk(rd, s);
      repeat (6)
      begin
        {pickup1, pickup2, flow_fwd, limit_hit} <= 4'($urandom);
        repeat (2) @(posedge pclk);
        chk(pulse_out1_o, exp_src(s));
      end
    end
    for (int s = 0; s < 3; s += 2)
    begin
      apb(1, OFS_CTRL, s, rd);
      {pickup1, pickup2} <= 2'b00;
      repeat (3) @(posedge pclk);
      lvl = edges;
      for (int k = 0; k < 16; k++)
      begin
        {pickup1, pickup2} <= gr[k % 4];
        @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
      chk(edges - lvl, (s == 2) ? 8 : 4);
    end
    for (int d = 1; d < 3; d++)
    begin
      pull_up <= (d == 1);
      apb(1, OFS_CTRL, 3 | (d << CTL_DRV_LSB), rd);
      repeat (4)
      begin
        flow_fwd <= 1'($urandom);
        repeat (2) @(posedge pclk);
        chk(pulse_out1_oe, (d == 1) ? !flow_fwd : flow_fwd);
        chk(pulse_out2_oe, (d == 1) ? !flow_fwd : flow_fwd);
        chk(line1, flow_fwd);
      end
    end
    pull_up <= 1'b1;
    apb(1, OFS_CTRL, 0, rd);
    apb(1, OFS_MASK, 0, rd);
    apb(0, OFS_IRQ, 0, rd);
    press();
    chk(test_state, ts_tab[1]);
    chk(irq, 0);
    apb(0, OFS_IRQ, 0, rd);
    chk(rd[0], 1);
    apb(1, OFS_MASK, 1, rd);
    for (int k = 2; k < 5; k++)
    begin
      press();
      chk(test_state, ts_tab[k % 3]);
      chk(irq, 1);
      apb(0, OFS_IRQ, 0, rd);
      @(posedge pclk);
      chk(rd[0], 1);
      chk(irq, 0);
      case (k % 3)
        2: qchk(Q50, 1);
        1: qchk(Q10, 0);
        default:
        begin
          wt(1, 0, n);
          wt(1, 1, n);
          n = 0;
          wt(1, 0, n);
          wt(1, 1, n);
          chk(n, LEDP);
        end
      endcase
    end
    apb(1, OFS_MASK, 0, rd);
    for (int k = 0; k < 4; k++)
    begin
      v = (k == 1) ? 32'h0000_FFF0 : $urandom_range(0, 32'h0000_DF00);
      apb(1, OFS_ANA, v, rd);
      apb(1, OFS_CTRL, (k == 3) << CTL_ERR_BIT, rd);
      repeat (2 * ANA) @(posedge pclk);
      apb(0, OFS_CODE, 0, rd);
      chk(ana_code, exp_ana(v, k == 3));
      chk(rd, exp_ana(v, k == 3));
      apb(0, OFS_IRQ, 0, rd);
      chk(rd[1], 1);
      if (k < 2) chk(rd[2], k == 1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
